// file: ovg_params.svh
// Register offsets, field positions, reset values and timing counts of the guard.
`ifndef OVG_PARAMS_SVH
`define OVG_PARAMS_SVH

`define OVG_GUARD_CONTROL_OFS      8'h00
`define OVG_TRIM_CONTROL_OFS       8'h04
`define OVG_DAC_CODE_OFS           8'h08
`define OVG_TIMER_CONTROL_OFS      8'h0C
`define OVG_TIMER_PERIOD_OFS       8'h10
`define OVG_TIMER_CAPTURE_OFS      8'h14
`define OVG_TIMER_STATUS_OFS       8'h18

`define OVG_ENABLE_BIT             5
`define OVG_HYST_BIT               4
`define OVG_VREF_BIT               2
`define OVG_DEB_LSB                0
`define OVG_RESULT_BIT             7
`define OVG_CALMODE_BIT            6
`define OVG_CALREF_BIT             5
`define OVG_TRIM_LSB               0

`define OVG_GUARD_CONTROL_RST      8'h00
`define OVG_TRIM_CONTROL_RST       8'h10
`define OVG_DAC_CODE_RST           8'h00
`define OVG_GUARD_CONTROL_MASK     8'h37
`define OVG_TRIM_CONTROL_MASK      8'h7F

`define OVG_DEB_CNT_01             5'h07
`define OVG_DEB_CNT_10             5'h0F
`define OVG_DEB_CNT_11             5'h1F

`endif

// file: ovg_pkg.sv
// Types shared by the over-voltage guard control block.
`default_nettype none
package ovg_pkg;
  typedef struct packed {
    logic       guard_enable;
    logic       hysteresis_enable;
    logic       dac_reference_select;
    logic       calibration_mode_select;
    logic       calibration_reference_select;
    logic [4:0] offset_trim;
    logic [7:0] threshold_dac_code;
  } ovg_analog_ctrl_t;

  typedef enum logic [2:0] {
    OVG_IDLE = 3'b001,
    OVG_RESP = 3'b010,
    OVG_DONE = 3'b100
  } ovg_bus_state_t;
endpackage
`default_nettype wire

// file: ovg_guard.sv
// Over-voltage guard control: registers, debounce, interrupt and capture timer.
//
// Functional notes
// RQ1: Guard interrupt raised on over-voltage event when its enable is set.
// RQ2: Guard interrupt signal drives the timer capture input path.
// RQ3: Enable bit 0 powers down comparator and DAC; 1 enables them.
// RQ4: Guard control bit 4 enables comparator hysteresis.
// RQ5: Guard control bit 2 selects DAC reference: supply or external pin.
// RQ6: Debounce field picks none, 7-8, 15-16 or 31-32 clocks.
// RQ7: Trim control bit 7 reads comparator result, read only.
// RQ8: Trim control bit 6 selects normal or offset calibration mode.
// RQ9: Trim control bit 5 selects calibration reference input polarity.
// RQ10: Five-bit offset trim held in low bits, applied to comparator.
// RQ11: Eight-bit code register drives the reference DAC.
// RQ12: Comparator output comes from pin voltage versus DAC reference.
// RQ13: Unimplemented control register bits read as zero.
// RQ14: Software disables hysteresis and sets pin function before calibration.
// RQ15: Software sets calibration mode and reference select to start.
// RQ16: Software ramps trim up from 00000, records first output change.
// RQ17: Software ramps trim down from 11111, records output change.
// RQ18: Software writes truncated average of both trim values.
// RQ19: Capture timer clears on period match, latches count on input edge.
// RQ20: Filtered result updates only after raw level is stable long enough.
`include "ovg_params.svh"
`default_nettype none
module ovg_guard
  import ovg_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      comparator_raw,
  output var  ovg_pkg::ovg_analog_ctrl_t analog_ctrl,
  output var  logic                      guard_interrupt_signal,
  output var  logic                      timer_interrupt
);
  import ovg_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  guard_control_q;
  logic [7:0]  trim_control_q;
  logic [7:0]  dac_code_q;
  logic        timer_run_q;
  logic [15:0] timer_period_q;
  logic [15:0] timer_capture_q;
  logic [15:0] timer_count_q;
  logic        capture_flag_q;
  logic        period_flag_q;
  logic [2:0]  raw_sync_q;
  logic [4:0]  deb_cnt_q;
  logic        result_q;
  logic        result_prev_q;

  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_ok;
  logic [4:0]  deb_limit;
  logic        raw_stable;
  logic        guard_event;
  logic        capture_edge;
  logic        period_match;
  logic        clr_capture;
  logic        clr_period;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      // Ready from the next held and response state
      s_axi_awready <= !wr_go && !aw_held_q && !(s_axi_awvalid && s_axi_awready)
                       && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready  <= !wr_go && !w_held_q && !(s_axi_wvalid && s_axi_wready)
                       && !(s_axi_bvalid && !s_axi_bready);
    end
  end

  always_comb
  begin
    unique case (aw_addr_q)
      `OVG_GUARD_CONTROL_OFS, `OVG_TRIM_CONTROL_OFS, `OVG_DAC_CODE_OFS,
      `OVG_TIMER_CONTROL_OFS, `OVG_TIMER_PERIOD_OFS, `OVG_TIMER_STATUS_OFS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Control registers, masked so unused bits stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      guard_control_q <= `OVG_GUARD_CONTROL_RST;
      trim_control_q  <= `OVG_TRIM_CONTROL_RST;
      dac_code_q      <= `OVG_DAC_CODE_RST;
      timer_run_q     <= 1'b0;
      timer_period_q  <= 16'h0000;
    end
    else if (wr_go && w_strb_q[0])
    begin
      unique case (aw_addr_q)
        `OVG_GUARD_CONTROL_OFS: guard_control_q <= w_data_q[7:0] & `OVG_GUARD_CONTROL_MASK; // see RQ13
        `OVG_TRIM_CONTROL_OFS:  trim_control_q  <= w_data_q[7:0] & `OVG_TRIM_CONTROL_MASK;  // see RQ10
        `OVG_DAC_CODE_OFS:      dac_code_q      <= w_data_q[7:0]; // see RQ11
        `OVG_TIMER_CONTROL_OFS: timer_run_q     <= w_data_q[0];
        `OVG_TIMER_PERIOD_OFS:  timer_period_q  <= {(w_strb_q[1] ? w_data_q[15:8]
                                                      : timer_period_q[15:8]), w_data_q[7:0]};
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // Ready from the next response state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= !rd_go && !(s_axi_rvalid && !s_axi_rready);
    end
  end

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OVG_GUARD_CONTROL_OFS: rd_word[7:0] = guard_control_q; // see RQ13
      `OVG_TRIM_CONTROL_OFS:  rd_word[7:0] = {result_q, trim_control_q[6:0]}; // see RQ7
      `OVG_DAC_CODE_OFS:      rd_word[7:0] = dac_code_q;
      `OVG_TIMER_CONTROL_OFS: rd_word[0]   = timer_run_q;
      `OVG_TIMER_PERIOD_OFS:  rd_word[15:0] = timer_period_q;
      `OVG_TIMER_CAPTURE_OFS: rd_word[15:0] = timer_capture_q;
      `OVG_TIMER_STATUS_OFS:  rd_word[1:0] = {period_flag_q, capture_flag_q};
      default:                rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Analog controls
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      analog_ctrl <= '0;
    end
    else
    begin
      analog_ctrl.guard_enable                 <= guard_control_q[`OVG_ENABLE_BIT];  // see RQ3
      analog_ctrl.hysteresis_enable            <= guard_control_q[`OVG_HYST_BIT];    // see RQ4
      analog_ctrl.dac_reference_select         <= guard_control_q[`OVG_VREF_BIT];    // see RQ5
      analog_ctrl.calibration_mode_select      <= trim_control_q[`OVG_CALMODE_BIT];  // see RQ8
      analog_ctrl.calibration_reference_select <= trim_control_q[`OVG_CALREF_BIT];   // see RQ9
      analog_ctrl.offset_trim                  <= trim_control_q[4:0];              // see RQ10
      analog_ctrl.threshold_dac_code           <= dac_code_q;                       // see RQ11
    end
  end

  // ----------------------------------------
  // Comparator sync and debounce
  // ----------------------------------------
  always_comb
  begin
    unique case (guard_control_q[1:0])
      2'b01:   deb_limit = `OVG_DEB_CNT_01;
      2'b10:   deb_limit = `OVG_DEB_CNT_10;
      2'b11:   deb_limit = `OVG_DEB_CNT_11;
      default: deb_limit = 5'h00;
    endcase
  end

  assign raw_stable = (raw_sync_q[2] == raw_sync_q[1]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raw_sync_q    <= 3'h0;
      deb_cnt_q     <= 5'h00;
      result_q      <= 1'b0;
      result_prev_q <= 1'b0;
    end
    else
    begin
      raw_sync_q    <= {raw_sync_q[1:0], comparator_raw}; // see RQ12
      result_prev_q <= result_q;
      if (!guard_control_q[`OVG_ENABLE_BIT])
      begin
        deb_cnt_q <= 5'h00;
        result_q  <= 1'b0; // see RQ3
      end
      else if (!raw_stable || raw_sync_q[2] == result_q)
      begin
        deb_cnt_q <= 5'h00;
      end
      else if (deb_cnt_q >= deb_limit)
      begin
        deb_cnt_q <= 5'h00;
        result_q  <= raw_sync_q[2]; // see RQ6 RQ20
      end
      else
      begin
        deb_cnt_q <= deb_cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Guard interrupt and capture timer
  // ----------------------------------------
  assign guard_event  = result_q && !result_prev_q;
  assign capture_edge = guard_interrupt_signal; // see RQ2
  assign period_match = timer_run_q && (timer_count_q == timer_period_q);
  assign clr_capture  = wr_go && w_strb_q[0] && aw_addr_q == `OVG_TIMER_STATUS_OFS && w_data_q[0];
  assign clr_period   = wr_go && w_strb_q[0] && aw_addr_q == `OVG_TIMER_STATUS_OFS && w_data_q[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      guard_interrupt_signal <= 1'b0;
    end
    else
    begin
      guard_interrupt_signal <= guard_event && guard_control_q[`OVG_ENABLE_BIT]; // see RQ1
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_count_q   <= 16'h0000;
      timer_capture_q <= 16'h0000;
      capture_flag_q  <= 1'b0;
      period_flag_q   <= 1'b0;
      timer_interrupt <= 1'b0;
    end
    else
    begin
      if (!timer_run_q || period_match)
      begin
        timer_count_q <= 16'h0000; // see RQ19
      end
      else
      begin
        timer_count_q <= timer_count_q + 16'h0001;
      end
      if (timer_run_q && capture_edge)
      begin
        timer_capture_q <= timer_count_q; // see RQ19
      end
      capture_flag_q  <= (timer_run_q && capture_edge) || (capture_flag_q && !clr_capture);
      period_flag_q   <= period_match || (period_flag_q && !clr_period);
      timer_interrupt <= period_match || (timer_run_q && capture_edge); // see RQ19
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence raw_held_s;
    raw_stable && raw_sync_q[2] != result_q;
  endsequence

  irq_cause_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ1
    $rose(result_q) && guard_control_q[5] |=> guard_interrupt_signal)
    else $error("guard interrupt missing");
  irq_route_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ2
    guard_interrupt_signal && timer_run_q |=> timer_capture_q == $past(timer_count_q))
    else $error("capture not taken on guard event");
  off_result_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ3
    !guard_control_q[5] |=> !result_q && !analog_ctrl.guard_enable[*1])
    else $error("result not cleared while disabled");
  nodeb_fast_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ6
    (guard_control_q[5] && guard_control_q[1:0] == 2'b00 && $stable(guard_control_q))
    and raw_held_s |=> result_q == $past(raw_sync_q[2]))
    else $error("no-debounce update late");
  deb_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ20
    guard_control_q[5] && guard_control_q[1:0] == 2'b11 && $changed(result_q)
    && $stable(guard_control_q)
    |-> $past(raw_sync_q[2], 8) == result_q)
    else $error("debounce updated too soon");
  hyst_map_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ4
    ##1 analog_ctrl.hysteresis_enable == $past(guard_control_q[4]))
    else $error("hysteresis control mismatch");
  unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ13
    (guard_control_q & ~8'h37) == 8'h00 && !trim_control_q[7])
    else $error("unused bits set");
  period_clr_a: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ19
    period_match |=> timer_count_q == 16'h0000 && timer_interrupt && period_flag_q)
    else $error("period match not handled");
endmodule
`default_nettype wire

// file: ovg_analog_model.sv
// Behavioural comparator and reference DAC facing the guard control block.
`default_nettype none
module ovg_analog_model
  import ovg_pkg::*;
#(
  parameter logic [4:0] CAL_POINT = 5'h0D
)
(
  input  wire logic                      aclk,
  input  wire ovg_pkg::ovg_analog_ctrl_t ctrl,
  input  wire logic [7:0]                pin_level,
  output var  logic                      comparator_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] thr;
  logic [7:0] hyst;

  // Trip point drops once tripped while hysteresis is on
  assign hyst = (ctrl.hysteresis_enable && comparator_raw) ? 8'h04 : 8'h00;
  assign thr  = ctrl.threshold_dac_code - hyst;

  always_ff @(posedge aclk)
  begin
    if (!ctrl.guard_enable)
      comparator_raw <= 1'b0;
    else if (ctrl.calibration_mode_select)
      comparator_raw <= (ctrl.offset_trim >= CAL_POINT)
                        ^ !ctrl.calibration_reference_select;
    else
      comparator_raw <= pin_level > thr;
  end
endmodule
`default_nettype wire

// file: overvoltage_guard_control_test.sv
// Self-checking testbench of the over-voltage guard control block.
`default_nettype none
module overvoltage_guard_control_test
  import ovg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL = 13;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, prev;
  logic awready, wready, bvalid, arready, rvalid, gint, tint, raw;
  logic [7:0]  awaddr, araddr, pin_level;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  ovg_analog_ctrl_t actl;
  int error_cnt, checked, cycles, k, lim, v1, v2;

  ovg_guard DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comparator_raw(raw), .analog_ctrl(actl),
    .guard_interrupt_signal(gint), .timer_interrupt(tint));
  ovg_analog_model #(.CAL_POINT(5'(CAL))) model (.aclk(aclk), .ctrl(actl),
    .pin_level(pin_level), .comparator_raw(raw));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 12000)
    begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a, v, r);
    check(v, exp);
  endtask

  task automatic count_irq(input int n, output int cnt);
    cnt = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (gint === 1'b1) cnt++;
    end
  endtask

  task automatic first(input bit tmr, input int n, output int cyc);
    cyc = -1;
    for (int i = 0; i < n && cyc < 0; i++)
    begin
      @(posedge aclk);
      if ((tmr ? tint : gint) === 1'b1) cyc = i;
    end
  endtask

  task automatic results();
    $display("Counts: checked=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, pin_level, wdata} = '0;
    wstrb = 4'hF;
    {error_cnt, checked, cycles} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h10);
    rdchk(8'h08, 32'h0);
    wr(8'h00, 32'hFFFF_FFDF);
    rdchk(8'h00, 32'h17);
    check(actl.hysteresis_enable, 32'h1);
    check(actl.dac_reference_select, 32'h1);
    check(actl.guard_enable, 32'h0);
    wr(8'h04, 32'hFF);
    rdchk(8'h04, 32'h7F);
    check({actl.calibration_mode_select, actl.calibration_reference_select,
           actl.offset_trim}, 32'h7F);
    wr(8'h08, 32'hA5);
    rdchk(8'h08, 32'hA5);
    check(actl.threshold_dac_code, 32'hA5);
    axw(8'h40, 32'h1, r);
    check(r, 32'h2);
    axr(8'h40, v, r);
    check(v, 32'h0);
    check(r, 32'h2);
    $display("Test done: registers");
    wr(8'h10, 32'd20);
    wr(8'h0C, 32'h1);
    first(1'b1, 60, k);
    check(k >= 0, 32'h1);
    axr(8'h18, v, r);
    check(v & 32'h2, 32'h2);
    wr(8'h10, 32'hFFFF);
    wr(8'h18, 32'h3);
    rdchk(8'h18, 32'h0);
    $display("Test done: timer");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h80);
    pin_level <= 8'hFF;
    count_irq(50, k);
    check(k, 32'h0);
    rdchk(8'h04, 32'h10);
    pin_level <= 8'h00;
    for (int d = 0; d < 4; d++)
    begin
      lim = (d == 0) ? 0 : (8 << (d - 1)) - 1;
      wr(8'h00, 32'h20 | d);
      repeat (60) @(posedge aclk);
      pin_level <= 8'hFF;
      repeat (4) @(posedge aclk);
      pin_level <= 8'h00;
      count_irq(60, k);
      check(k, d == 0);
      pin_level <= 8'hFF;
      first(1'b0, 80, k);
      check(k >= lim && k <= lim + 8, 32'h1);
      rdchk(8'h04, 32'h90);
      pin_level <= 8'h00;
      repeat (60) @(posedge aclk);
      rdchk(8'h04, 32'h10);
    end
    axr(8'h18, v, r);
    check(v & 32'h1, 32'h1);
    $display("Test done: debounce");
    wr(8'h00, 32'h20);
    {v1, v2} = '0;
    for (int t = 0; t < 32; t++)
    begin
      wr(8'h04, 32'h60 | t);
      repeat (8) @(posedge aclk);
      axr(8'h04, v, r);
      if (t == 0) prev = v[7];
      else if (v[7] !== prev && v1 == 0) v1 = t;
    end
    for (int t = 31; t >= 0; t--)
    begin
      wr(8'h04, 32'h60 | t);
      repeat (8) @(posedge aclk);
      axr(8'h04, v, r);
      if (t == 31) prev = v[7];
      else if (v[7] !== prev && v2 == 0) v2 = t;
    end
    check(v1, CAL);
    check(v2, CAL - 1);
    wr(8'h04, (v1 + v2) / 2);
    repeat (2) @(posedge aclk);
    check(actl.offset_trim, (2 * CAL - 1) / 2);
    rdchk(8'h04, (2 * CAL - 1) / 2);
    $display("Test done: calibration");
    results();
  end
endmodule
`default_nettype wire
